//--- src/usc_consts.vh
`ifndef USC_CONSTS_VH
`define USC_CONSTS_VH
// ---------------------------------------------------------------
// register byte offsets (per instance window)
// ---------------------------------------------------------------
`define USC_OFF_DATA 8'h00
`define USC_OFF_CSA 8'h04
`define USC_OFF_CSB 8'h08
`define USC_OFF_CSC 8'h0C
`define USC_OFF_DIV 8'h10
`define USC_OFF_PWR 8'h14
// instance select bit in haddr
`define USC_INST_BIT 8
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define USC_CSA_RXC 7
`define USC_CSA_TXC 6
`define USC_CSA_UDRE 5
`define USC_CSA_FE 4
`define USC_CSA_DOR 3
`define USC_CSA_PE 2
`define USC_CSA_U2X 1
`define USC_CSB_RXCIE 7
`define USC_CSB_TXCIE 6
`define USC_CSB_UDRIE 5
`define USC_CSB_RXEN 4
`define USC_CSB_TXEN 3
`define USC_CSB_SZ2 2
`define USC_CSB_TX8 0
`define USC_CSC_SYNC 6
`define USC_CSC_PAREN 5
`define USC_CSC_PARODD 4
`define USC_CSC_STOP2 3
`define USC_CSC_DIR 0
`define USC_DIV_W 12
// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define USC_RST_CSA 8'h20
`define USC_RST_CSB 8'h00
`define USC_RST_CSC 8'h06
`define USC_RST_DIV 12'h000
`define USC_RST_PWR 1'b1
`define USC_DIV_NORM 5'h10
`define USC_DIV_DBL 5'h08
`define USC_DIV_SYNC 5'h02
`define USC_MID_NORM 5'h08
`define USC_MID_DBL 5'h04
`endif

//--- src/usc_channel.v
`timescale 1ns/1ps
`include "usc_consts.vh"
module usc_channel (
   hclk,
   hresetn,
   wr_en,
   rd_en,
   wr_off,
   wdata,
   rdata,
   txd,
   rxd,
   xck_in,
   xck_out,
   xck_oe,
   irq_rxc,
   irq_txc,
   irq_udre
);
input wire hclk;
input wire hresetn;
input wire wr_en;
input wire rd_en;
input wire [7:0] wr_off;
input wire [31:0] wdata;
output reg [31:0] rdata;
output reg txd;
input wire rxd;
input wire xck_in;
output reg xck_out;
output wire xck_oe;
output wire irq_rxc;
output wire irq_txc;
output wire irq_udre;

// ---------------------------------------------------------------
// registers
// ---------------------------------------------------------------
reg [7:0] csb_reg;
reg [7:0] csc_reg;
reg dbl_reg;
reg [11:0] div_reg;
reg pwr_reg;
reg [11:0] cnt_reg;
reg [1:0] rx_sync_reg;
reg [1:0] xk_sync_reg;
reg xk_last_reg;
wire on = ~pwr_reg; // RULE_21
wire sync_mode_select = csc_reg[`USC_CSC_SYNC];
wire dir = csc_reg[`USC_CSC_DIR];
wire slave = sync_mode_select & ~dir;
wire dbl = dbl_reg & ~sync_mode_select;
wire div_wr = wr_en & (wr_off == `USC_OFF_DIV);
wire data_wr = wr_en & (wr_off == `USC_OFF_DATA);

// ---------------------------------------------------------------
// baud generator
// ---------------------------------------------------------------
wire tick = on & (cnt_reg == 12'h000); // RULE_02
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      cnt_reg <= `USC_RST_DIV;
   end else if (div_wr) begin
      cnt_reg <= wdata[`USC_DIV_W-1:0]; // RULE_01
   end else if (on) begin
      if (cnt_reg == 12'h000) begin
         cnt_reg <= div_reg;
      end else begin
         cnt_reg <= cnt_reg - 12'h001;
      end
   end
end

// ---------------------------------------------------------------
// external clock sync and edge detect
// ---------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      rx_sync_reg <= 2'b11;
      xk_sync_reg <= 2'b00;
      xk_last_reg <= 1'b0;
   end else begin
      rx_sync_reg <= {rx_sync_reg[0], rxd};
      xk_sync_reg <= {xk_sync_reg[0], xck_in}; // RULE_12
      xk_last_reg <= xk_sync_reg[1];
   end
end
wire xk_rise = xk_sync_reg[1] & ~xk_last_reg; // RULE_24
wire xk_fall = ~xk_sync_reg[1] & xk_last_reg;

// ---------------------------------------------------------------
// mode select and transmit divider
// ---------------------------------------------------------------
wire [4:0] tx_div = sync_mode_select ? `USC_DIV_SYNC : // RULE_03
   (dbl ? `USC_DIV_DBL : `USC_DIV_NORM); // RULE_05 RULE_06
reg [4:0] txdiv_reg;
wire tx_base = slave ? (on & xk_rise) : tick; // RULE_11
wire txclk = slave ? (on & xk_fall) :
   (tick & (txdiv_reg == tx_div - 5'h01));
wire rx_samp_sync = slave ? (on & xk_rise) :
   (tick & (txdiv_reg == 5'h00));
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      txdiv_reg <= 5'h00;
      xck_out <= 1'b0;
   end else if (tx_base) begin
      if (txdiv_reg >= tx_div - 5'h01) begin
         txdiv_reg <= 5'h00;
      end else begin
         txdiv_reg <= txdiv_reg + 5'h01;
      end
      if (sync_mode_select & dir & on) begin
         xck_out <= (txdiv_reg == 5'h00);
      end else begin
         xck_out <= 1'b0;
      end
   end
end
assign xck_oe = sync_mode_select & dir; // RULE_08 RULE_09

// ---------------------------------------------------------------
// transmitter
// ---------------------------------------------------------------
localparam TX_IDLE = 2'b01;
localparam TX_BUSY = 2'b10;
reg [1:0] tx_state_reg;
reg [8:0] wbuf_reg;
reg wfull_reg;
reg [11:0] tsh_reg;
reg [3:0] tcnt_reg;
reg txc_reg;
wire [2:0] sz = {csb_reg[`USC_CSB_SZ2], csc_reg[2:1]};
wire [3:0] nbits = (sz == 3'h7) ? 4'h9 : ({1'b0, sz} + 4'h5); // RULE_17
wire [8:0] wmask = (9'h1FF >> (4'h9 - nbits));
wire tx_on = on & csb_reg[`USC_CSB_TXEN];
wire [8:0] wd = wbuf_reg & wmask;
wire wpar = (^wd) ^ csc_reg[`USC_CSC_PARODD]; // RULE_18
wire [3:0] tlen = 4'h1 + nbits + {3'h0, csc_reg[`USC_CSC_PAREN]} +
   {3'h0, csc_reg[`USC_CSC_STOP2]} + 4'h1;
reg [11:0] tframe;
always @* begin
   tframe = {3'h7, wd} | ~{3'h7, wmask};
   tframe[nbits] = csc_reg[`USC_CSC_PAREN] ? wpar : 1'b1;
   tframe = {tframe[10:0], 1'b0};
end
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      tx_state_reg <= TX_IDLE;
      wbuf_reg <= 9'h000;
      wfull_reg <= 1'b0;
      tsh_reg <= 12'hFFF;
      tcnt_reg <= 4'h0;
      txc_reg <= 1'b0;
      txd <= 1'b1;
   end else begin
      if (data_wr & tx_on) begin
         wbuf_reg <= {csb_reg[`USC_CSB_TX8], wdata[7:0]};
         wfull_reg <= 1'b1;
         txc_reg <= 1'b0;
      end
      if (wr_en & (wr_off == `USC_OFF_CSA) & wdata[`USC_CSA_TXC]) begin
         txc_reg <= 1'b0;
      end
      if (txclk & tx_on) begin
         case (tx_state_reg)
            TX_IDLE: begin
               if (wfull_reg) begin
                  tsh_reg <= tframe;
                  tcnt_reg <= tlen;
                  wfull_reg <= data_wr;
                  tx_state_reg <= TX_BUSY;
               end
            end
            TX_BUSY: begin
               txd <= tsh_reg[0];
               tsh_reg <= {1'b1, tsh_reg[11:1]};
               if (tcnt_reg == 4'h1) begin
                  if (wfull_reg) begin // RULE_13
                     tsh_reg <= tframe;
                     tcnt_reg <= tlen;
                     wfull_reg <= data_wr;
                  end else begin
                     tx_state_reg <= TX_IDLE;
                     txc_reg <= 1'b1; // RULE_20
                  end
               end else begin
                  tcnt_reg <= tcnt_reg - 4'h1;
               end
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end
end

// ---------------------------------------------------------------
// receiver
// ---------------------------------------------------------------
localparam RX_IDLE = 3'b001;
localparam RX_DATA = 3'b010;
localparam RX_STOP = 3'b100;
reg [2:0] rx_state_reg;
reg [4:0] rph_reg;
reg [2:0] vote_reg;
reg [9:0] rsh_reg;
reg [3:0] rcnt_reg;
reg [10:0] rbuf0_reg;
reg [10:0] rbuf1_reg;
reg [1:0] rlvl_reg;
reg dor_pend_reg;
wire rx_on = on & csb_reg[`USC_CSB_RXEN];
wire [4:0] rdiv = dbl ? `USC_DIV_DBL : `USC_DIV_NORM;
wire [4:0] rmid = dbl ? `USC_MID_DBL : `USC_MID_NORM;
wire filt = (vote_reg[0] & vote_reg[1]) | (vote_reg[1] & vote_reg[2]) |
   (vote_reg[0] & vote_reg[2]);
wire rsamp = sync_mode_select ? rx_samp_sync :
   (tick & (rph_reg == rmid));
wire rbit = sync_mode_select ? rx_sync_reg[1] : filt;
wire [3:0] rlen = nbits + {3'h0, csc_reg[`USC_CSC_PAREN]};
// without parity the data sit one place higher in the shifter
wire [9:0] ralign = csc_reg[`USC_CSC_PAREN] ? rsh_reg :
   {1'b0, rsh_reg[9:1]};
wire [8:0] rdat = (ralign[8:0] >> (4'h9 - nbits)) & wmask;
wire rpar = rsh_reg[9];
wire perr = csc_reg[`USC_CSC_PAREN] & // RULE_18
   ((^rdat) ^ csc_reg[`USC_CSC_PARODD] ^ rpar);
wire rd_data = rd_en & (wr_off == `USC_OFF_DATA) & (rlvl_reg != 2'h0);
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      rx_state_reg <= RX_IDLE;
      rph_reg <= 5'h00;
      vote_reg <= 3'h7;
      rsh_reg <= 10'h000;
      rcnt_reg <= 4'h0;
      rbuf0_reg <= 11'h000;
      rbuf1_reg <= 11'h000;
      rlvl_reg <= 2'h0;
      dor_pend_reg <= 1'b0;
   end else begin
      if (tick) begin // RULE_19
         vote_reg <= {vote_reg[1:0], rx_sync_reg[1]};
         rph_reg <= (rph_reg >= rdiv - 5'h01) ? 5'h00 :
            rph_reg + 5'h01; // RULE_04
      end
      if (rd_data) begin
         rbuf0_reg <= rbuf1_reg;
         rlvl_reg <= rlvl_reg - 2'h1;
      end
      if (!rx_on) begin
         rx_state_reg <= RX_IDLE;
      end else begin
         case (rx_state_reg)
            RX_IDLE: begin
               if (!sync_mode_select && tick && !vote_reg[0] && filt) begin
                  rph_reg <= 5'h01; // RULE_15
               end
               if (rsamp & ~rbit) begin // RULE_19
                  rx_state_reg <= RX_DATA;
                  rcnt_reg <= rlen;
               end
            end
            RX_DATA: begin
               if (rsamp) begin
                  rsh_reg <= {rbit, rsh_reg[9:1]};
                  if (rcnt_reg == 4'h1) begin
                     rx_state_reg <= RX_STOP;
                  end
                  rcnt_reg <= rcnt_reg - 4'h1;
               end
            end
            RX_STOP: begin
               if (rsamp) begin // RULE_16
                  rx_state_reg <= RX_IDLE;
                  if ((rlvl_reg == 2'h2) & ~rd_data) begin
                     dor_pend_reg <= 1'b1;
                  end else if ((rlvl_reg == 2'h0) |
                     ((rlvl_reg == 2'h1) & rd_data)) begin // RULE_14
                     rbuf0_reg <= {~rbit, perr, rdat};
                     rlvl_reg <= rd_data ? rlvl_reg : rlvl_reg + 2'h1;
                  end else begin
                     rbuf1_reg <= {~rbit, perr, rdat};
                     rlvl_reg <= rd_data ? rlvl_reg : rlvl_reg + 2'h1;
                  end
               end
            end
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
      if (rd_data) begin
         dor_pend_reg <= 1'b0;
      end
   end
end

// ---------------------------------------------------------------
// register writes and reads
// ---------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      csb_reg <= `USC_RST_CSB;
      csc_reg <= `USC_RST_CSC;
      dbl_reg <= 1'b0;
      div_reg <= `USC_RST_DIV; // RULE_25
      pwr_reg <= `USC_RST_PWR; // RULE_21
   end else if (wr_en) begin
      case (wr_off)
         `USC_OFF_CSA: dbl_reg <= wdata[`USC_CSA_U2X]; // RULE_10
         `USC_OFF_CSB: csb_reg <= wdata[7:0];
         `USC_OFF_CSC: csc_reg <= wdata[7:0]; // RULE_07
         `USC_OFF_DIV: div_reg <= wdata[`USC_DIV_W-1:0]; // RULE_23
         `USC_OFF_PWR: pwr_reg <= wdata[0];
         default: pwr_reg <= pwr_reg;
      endcase
   end
end
wire [7:0] csa = {rlvl_reg != 2'h0, txc_reg, ~wfull_reg,
   rbuf0_reg[10], dor_pend_reg, rbuf0_reg[9], dbl_reg, 1'b0};
always @* begin
   case (wr_off)
      `USC_OFF_DATA: rdata = {24'h000000, rbuf0_reg[7:0]};
      `USC_OFF_CSA: rdata = {24'h000000, csa};
      `USC_OFF_CSB: rdata = {24'h000000, csb_reg[7:2],
         rbuf0_reg[8], csb_reg[0]};
      `USC_OFF_CSC: rdata = {24'h000000, csc_reg};
      `USC_OFF_DIV: rdata = {20'h00000, div_reg};
      `USC_OFF_PWR: rdata = {31'h00000000, pwr_reg};
      default: rdata = 32'h00000000;
   endcase
end
assign irq_rxc = csb_reg[`USC_CSB_RXCIE] & (rlvl_reg != 2'h0);
assign irq_txc = csb_reg[`USC_CSB_TXCIE] & txc_reg;
assign irq_udre = csb_reg[`USC_CSB_UDRIE] & ~wfull_reg;
endmodule // usc_channel

//--- src/usc_top.v
`timescale 1ns/1ps
`include "usc_consts.vh"
// Operation
// RULE_01 - counter reloads at zero or divisor write
// RULE_02 - tick rate is clock over divisor+1
// RULE_03 - transmit divides tick by 2/8/16
// RULE_04 - receive phase counter of 8/16 states
// RULE_05 - normal async bit rate clock/16(div+1)
// RULE_06 - double speed bit rate clock/8(div+1)
// RULE_07 - mode bit selects async or sync
// RULE_08 - pin direction picks master or slave
// RULE_09 - clock pin used only in sync
// RULE_10 - double speed only affects async
// RULE_11 - slave uses external clock, others internal
// RULE_12 - external clock synchronised before use
// RULE_13 - single write buffer, gapless frames
// RULE_14 - receive buffer two entries deep
// RULE_15 - recovery units for async reception
// RULE_16 - flag frame, overrun, parity errors
// RULE_17 - five to nine data, 1-2 stops
// RULE_18 - odd or even parity generated, checked
// RULE_19 - majority filter, false start rejection
// RULE_20 - three interrupt requests per instance
// RULE_21 - instance runs only when power bit clear
// RULE_22 - two instances, separate registers
// RULE_23 - twelve-bit baud divisor
// RULE_24 - synchroniser plus edge detect delay
// RULE_25 - divisor and counter reset to zero
module usc_top (
   hclk,
   hresetn,
   hsel,
   haddr,
   htrans,
   hwrite,
   hsize,
   hwdata,
   hready,
   hreadyout,
   hresp,
   hrdata,
   txd,
   rxd,
   xck_in,
   xck_out,
   xck_oe,
   irq_rxc,
   irq_txc,
   irq_udre
);
input wire hclk;
input wire hresetn;
input wire hsel;
input wire [31:0] haddr;
input wire [1:0] htrans;
input wire hwrite;
input wire [2:0] hsize;
input wire [31:0] hwdata;
input wire hready;
output wire hreadyout;
output wire hresp;
output wire [31:0] hrdata;
output wire [1:0] txd;
input wire [1:0] rxd;
input wire [1:0] xck_in;
output wire [1:0] xck_out;
output wire [1:0] xck_oe;
output wire [1:0] irq_rxc;
output wire [1:0] irq_txc;
output wire [1:0] irq_udre;

// ---------------------------------------------------------------
// ahb-lite slave
// ---------------------------------------------------------------
reg wr_ph_reg;
reg rd_ph_reg;
reg inst_reg;
reg [7:0] off_reg;
wire [31:0] ch_rdata [0:1];
wire req = hsel & hready & htrans[1];
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      wr_ph_reg <= 1'b0;
      rd_ph_reg <= 1'b0;
      inst_reg <= 1'b0;
      off_reg <= 8'h00;
   end else if (hready) begin
      wr_ph_reg <= req & hwrite;
      rd_ph_reg <= req & ~hwrite;
      inst_reg <= haddr[`USC_INST_BIT];
      off_reg <= haddr[7:0];
   end
end
assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign hrdata = inst_reg ? ch_rdata[1] : ch_rdata[0];

// ---------------------------------------------------------------
// two instances
// ---------------------------------------------------------------
genvar gi;
generate
   for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
      usc_channel u_ch ( // RULE_22
         .hclk(hclk),
         .hresetn(hresetn),
         .wr_en(wr_ph_reg & (inst_reg == gi)),
         .rd_en(rd_ph_reg & (inst_reg == gi)),
         .wr_off(off_reg),
         .wdata(hwdata),
         .rdata(ch_rdata[gi]),
         .txd(txd[gi]),
         .rxd(rxd[gi]),
         .xck_in(xck_in[gi]), // RULE_12 RULE_24
         .xck_out(xck_out[gi]), // RULE_11
         .xck_oe(xck_oe[gi]), // RULE_08 RULE_09
         .irq_rxc(irq_rxc[gi]),
         .irq_txc(irq_txc[gi]),
         .irq_udre(irq_udre[gi])
      );
   end
endgenerate
endmodule // usc_top

//--- tb/usc_top_sva.sv
`timescale 1ns/1ps
// ----
// port checks
// ----
module usc_top_sva (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   input wire [1:0] txd,
   input wire [1:0] xck_out,
   input wire [1:0] xck_oe,
   input wire [1:0] irq_rxc,
   input wire [1:0] irq_txc,
   input wire [1:0] irq_udre
);
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
logic dw;
logic dr;
logic last;
logic pwr1;
logic [8:0] da;
logic [11:0] div0;
logic [12:0] cnt;
logic [1:0] tg;
wire chg = xck_out[0] != last;
// data phase tracking, divisor and power shadow, clock half period
always_ff @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      dw <= 1'h0;
      dr <= 1'h0;
      da <= 9'h000;
      div0 <= 12'h000;
      pwr1 <= 1'h1;
      last <= 1'h0;
      cnt <= 13'h0000;
      tg <= 2'h0;
   end else begin
      dw <= hsel && hready && htrans[1] && hwrite;
      dr <= hsel && hready && htrans[1] && !hwrite;
      da <= haddr[8:0];
      last <= xck_out[0];
      cnt <= chg ? 13'h0001 : cnt + 13'h0001;
      if (dw && da == 9'h010)
         div0 <= hwdata[11:0];
      if (dw && da == 9'h114)
         pwr1 <= hwdata[0];
      if (!xck_oe[0] || (dw && da == 9'h010))
         tg <= 2'h0;
      else if (chg && tg != 2'h2)
         tg <= tg + 2'h1;
   end
end
sequence s_toggle;
   xck_oe[0] && tg == 2'h2 && chg;
endsequence
a_ready_high: assert property (hreadyout == 1'h1)
   else $error("hreadyout low");
a_resp_okay: assert property (hresp == 1'h0)
   else $error("hresp not okay");
a_unmapped_zero: assert property (dr && da[7:0] > 8'h14 |-> hrdata == 32'h0)
   else $error("unmapped read not zero");
a_div_readback: assert property (dr && da == 9'h010 |-> hrdata[11:0] == div0)
   else $error("divisor readback wrong");
a_oe_cause: assert property ($changed(xck_oe) |-> $past(dw))
   else $error("clock enable moved without write");
a_xck_half: assert property (s_toggle |-> cnt == {1'h0, div0} + 13'h0001)
   else $error("master clock half period wrong");
a_reset_quiet: assert property ($rose(hresetn) |-> xck_oe == 2'h0 &&
   txd == 2'h3 && irq_rxc == 2'h0 && irq_txc == 2'h0 && irq_udre == 2'h0)
   else $error("outputs not idle after reset");
a_off_idle: assert property (pwr1 |-> txd[1] == 1'h1 && !xck_oe[1])
   else $error("powered off instance active");
endmodule // usc_top_sva

bind usc_top usc_top_sva usc_top_sva_inst (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .txd(txd), .xck_out(xck_out),
   .xck_oe(xck_oe), .irq_rxc(irq_rxc), .irq_txc(irq_txc),
   .irq_udre(irq_udre));

//--- tb/usc_peer.sv
`timescale 1ns/1ps
// ----
// remote serial peer
// ----
module usc_peer (
   input wire hclk,
   input wire [15:0] bit_cycles,
   input wire line_in,
   output logic line_out
);
logic [7:0] got_byte;
int got_count;
initial begin
   line_out = 1'h1;
   got_byte = 8'h00;
   got_count = 0;
end
// start, eight data lsb first, one stop
always begin : capture
   @(negedge line_in);
   repeat (bit_cycles / 2) @(posedge hclk);
   if (line_in === 1'h0) begin
      for (int i = 0; i < 8; i++) begin
         repeat (bit_cycles) @(posedge hclk);
         got_byte[i] = line_in;
      end
      repeat (bit_cycles) @(posedge hclk);
      if (line_in === 1'h1)
         got_count++;
   end
end
// same frame format back to the receiver, idle high
task automatic send(input logic [7:0] b);
   logic [9:0] f;
   f = {1'h1, b, 1'h0};
   for (int i = 0; i < 10; i++) begin
      @(posedge hclk);
      line_out <= f[i];
      repeat (bit_cycles - 1) @(posedge hclk);
   end
endtask
endmodule // usc_peer

//--- tb/usc_top_test.sv
`timescale 1ns/1ps
// ----
// register, serial transfer and clock generation bench
// ----
module usc_top_test;
typedef struct {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] m;}
   usc_row_t;
logic hclk = 1'h0;
logic hresetn = 1'h0;
logic hsel = 1'h0;
logic [31:0] haddr = 32'h0;
logic [1:0] htrans = 2'h0;
logic hwrite = 1'h0;
logic [31:0] hwdata = 32'h0;
logic [15:0] bitc = 16'h0020;
logic xck_in0 = 1'h0;
logic [31:0] rd;
wire hready;
wire hreadyout;
wire hresp;
wire [31:0] hrdata;
wire [1:0] txd;
wire [1:0] xck_out;
wire [1:0] xck_oe;
wire rx0;
int err_count = 0;
int cmp_count = 0;
int lo;
int hi;
usc_row_t rows [12] = '{
   '{1'h0, 32'h4, 32'h20, 32'hFF}, '{1'h0, 32'hC, 32'h6, 32'hFF},
   '{1'h0, 32'h10, 32'h0, 32'hFFF}, '{1'h0, 32'h14, 32'h1, 32'h1},
   '{1'h0, 32'h104, 32'h20, 32'hFF}, '{1'h1, 32'h10, 32'hFFFF, 32'h0},
   '{1'h0, 32'h10, 32'hFFF, 32'hFFF}, '{1'h0, 32'h110, 32'h0, 32'hFFF},
   '{1'h1, 32'h18, 32'hFF, 32'h0}, '{1'h0, 32'h18, 32'h0, 32'hFFFFFFFF},
   '{1'h1, 32'h110, 32'h123, 32'h0}, '{1'h0, 32'h110, 32'h123, 32'hFFF}};
assign hready = hreadyout;
always #25 hclk = ~hclk;
usc_top usc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .txd(txd), .rxd({1'h1, rx0}), .xck_in({1'h0, xck_in0}),
   .xck_out(xck_out), .xck_oe(xck_oe), .irq_rxc(), .irq_txc(),
   .irq_udre());
usc_peer usc_peer_inst (.hclk(hclk), .bit_cycles(bitc), .line_in(txd[0]),
   .line_out(rx0));
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   cmp_count++;
   if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
   end
endtask
task automatic chk_n(input int got, input int exp);
   cmp_count++;
   if (got != exp) begin
      err_count++;
      $display("CHECK FAILED %0t count %0d expected %0d", $time, got, exp);
   end
endtask
task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
   hsel <= 1'h1;
   htrans <= 2'h2;
   haddr <= a;
   hwrite <= w;
   @(posedge hclk);
   while (hready !== 1'h1) @(posedge hclk);
   hsel <= 1'h0;
   htrans <= 2'h0;
   hwdata <= d;
   @(posedge hclk);
   while (hready !== 1'h1) @(posedge hclk);
   rd = hrdata;
endtask
function automatic logic pick(input int s);
   return s ? xck_out[0] : txd[0];
endfunction
// low and high spans of the next full pulse
task automatic span(input int s);
   lo = 0;
   hi = 0;
   while (pick(s) !== 1'h1) @(posedge hclk);
   while (pick(s) !== 1'h0) @(posedge hclk);
   while (pick(s) === 1'h0) begin
      lo++;
      @(posedge hclk);
   end
   while (pick(s) === 1'h1) begin
      hi++;
      @(posedge hclk);
   end
endtask
task automatic wrap_up;
   $display("mismatches %0d compares %0d", err_count, cmp_count);
   if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
   else
      $display("Simulation failed");
   $finish;
endtask
initial begin
   repeat (20000) @(posedge hclk);
   err_count++;
   wrap_up;
end
initial begin
   repeat (6) @(posedge hclk);
   hresetn <= 1'h1;
   foreach (rows[i]) begin
      ahb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
         chk(rd & rows[i].m, rows[i].d);
   end
   ahb(1'h1, 32'h14, 32'h0);
   ahb(1'h1, 32'h10, 32'h1);
   ahb(1'h1, 32'h8, 32'h18);
   ahb(1'h1, 32'h0, 32'hA5);
   span(0);
   chk_n(lo, 32);
   while (usc_peer_inst.got_count < 1) @(posedge hclk);
   chk({24'h0, usc_peer_inst.got_byte}, 32'hA5);
   ahb(1'h0, 32'h4, 32'h0);
   chk(rd & 32'h60, 32'h60);
   ahb(1'h1, 32'h4, 32'h2);
   bitc <= 16'h0010;
   ahb(1'h1, 32'h0, 32'hA5);
   span(0);
   chk_n(lo, 16);
   while (usc_peer_inst.got_count < 2) @(posedge hclk);
   fork
      span(0);
      begin
         ahb(1'h1, 32'h0, 32'hFF);
         do
            ahb(1'h0, 32'h4, 32'h0);
         while (rd[5] !== 1'h1);
         ahb(1'h1, 32'h0, 32'hFF);
      end
   join
   chk_n(lo + hi, 160);
   while (usc_peer_inst.got_count < 4) @(posedge hclk);
   usc_peer_inst.send(8'h3C);
   usc_peer_inst.send(8'hC3);
   repeat (32) @(posedge hclk);
   ahb(1'h0, 32'h4, 32'h0);
   chk(rd & 32'h80, 32'h80);
   ahb(1'h0, 32'h0, 32'h0);
   chk(rd & 32'hFF, 32'h3C);
   ahb(1'h0, 32'h0, 32'h0);
   chk(rd & 32'hFF, 32'hC3);
   ahb(1'h1, 32'hC, 32'h47);
   ahb(1'h1, 32'h0, 32'h55);
   chk({30'h0, xck_oe}, 32'h1);
   span(1);
   chk_n(lo + hi, 4);
   ahb(1'h1, 32'hC, 32'h46);
   repeat (2) @(posedge hclk);
   chk({30'h0, xck_oe}, 32'h0);
   // slave: transmitter frozen while the external clock stands still
   ahb(1'h1, 32'h0, 32'h00);
   lo = int'(txd[0]);
   hi = 0;
   repeat (100) begin
      @(posedge hclk);
      if (txd[0] !== lo[0])
         hi++;
   end
   chk_n(hi, 0);
   hi = 0;
   repeat (120) begin
      xck_in0 <= ~xck_in0;
      repeat (4) @(posedge hclk);
      if (txd[0] !== lo[0]) begin
         hi++;
         lo = int'(txd[0]);
      end
   end
   chk_n(int'(hi > 0), 1);
   ahb(1'h1, 32'hC, 32'h07);
   repeat (2) @(posedge hclk);
   chk({30'h0, xck_oe}, 32'h0);
   ahb(1'h1, 32'h110, 32'h0);
   ahb(1'h1, 32'h108, 32'h8);
   ahb(1'h1, 32'h100, 32'h5A);
   hi = 0;
   repeat (400) begin
      @(posedge hclk);
      if (txd[1] !== 1'h1)
         hi++;
   end
   chk_n(hi, 0);
   hresetn <= 1'h0;
   repeat (2) @(posedge hclk);
   hresetn <= 1'h1;
   ahb(1'h0, 32'h10, 32'h0);
   chk(rd & 32'hFFF, 32'h0);
   chk({30'h0, xck_oe}, 32'h0);
   wrap_up;
end
endmodule // usc_top_test
